// ===== rtl/dacuc_pkg.sv
// Package with the constants and carrier types of the DAC update control.
package dacuc_pkg;
    // Register offsets (byte addresses within the board window).
    localparam logic [6:0] TRIG_BYTE_OFS  = 7'h01;
    localparam logic [6:0] CTRL_BYTE_OFS  = 7'h02;
    localparam logic [6:0] DAC_FIRST_OFS  = 7'h08;
    localparam logic [6:0] DAC_LAST_OFS   = 7'h16;
    // Field positions inside the control word.
    localparam int LAMP_BIT   = 15;
    localparam int FIELD_BIT  = 14;
    localparam int SYNC_BIT   = 13;
    localparam int SIGNED_BIT = 10;
    localparam int TMODE_LO   = 8;
    // Values after reset, flag codes and sizes.
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [1:0] FLAGS_NONE = 2'h0;
    localparam logic [1:0] FLAGS_ONE  = 2'h1;
    localparam logic [1:0] FLAGS_OVER = 2'h3;
    localparam int         NUM_CH     = 8;
    localparam int         DAC_W      = 12;

    typedef enum logic [1:0] {
        TM_AUTO, TM_EXT_RISE, TM_EXT_FALL, TM_INTERNAL
    } dacuc_tmode_type;

    typedef struct packed {
        logic            lamp_off;
        logic            field_connect;
        logic            sync_drive;
        logic            signed_fmt;
        dacuc_tmode_type tmode;
    } dacuc_ctrl_type;

    typedef struct packed {
        logic [6:0]  addr;
        logic        wr;
        logic        rd;
        logic [1:0]  lane;
        logic [15:0] wdata;
    } dacuc_bus_type;
endpackage

// ===== rtl/dacuc_top.sv
// Control byte, trigger policy and DAC input/output register transfer.
`timescale 1ns/100ps

// Notes on behaviour
// - Control bit 15 one turns lamp off; reset zero, lamp lit.
// - Control bit 14 connects DAC outputs to field wiring.
// - Control bit 13 one pulls trigger pin low.
// - Control bit 10 selects signed data; reset clears it.
// - Mode field: 00 auto, 01 rising, 10 falling, 11 internal.
// - Trigger copies every input register into its output register.
// - All eight channels take the strobe in the same cycle.
// - Edge to strobe latency is fixed and minimal.
// - Auto mode passes each input write straight to its output.
// - Internal mode: any trigger byte write transfers, data ignored.
// - External modes: only the selected pin edge transfers.
// - External: trigger write clears flags; edge sets 01, then 11.
module dacuc_top
    import dacuc_pkg::*;
(
    // Clock and reset.
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // Register access from the host bus interface.
    input  wire dacuc_bus_type        bus,
    output logic [15:0]               rdata,
    // External trigger pin, open drain.
    input  wire logic                 trig_pin_in,
    output logic                      trig_pin_out,
    output logic                      trig_pin_oe,
    // Board outputs.
    output logic                      status_lamp_on,
    output logic                      field_connect,
    output logic                      signed_fmt,
    output logic                      transfer_strobe,
    output logic [NUM_CH*DAC_W-1:0]   dac_out
);
    dacuc_ctrl_type         control_word_r;
    logic [1:0]             trigger_event_flags_r;
    logic [DAC_W-1:0]       in_r [NUM_CH];
    logic [DAC_W-1:0]       out_r [NUM_CH];
    logic [2:0]             trig_sync_r;
    logic                   rise;
    logic                   fall;
    logic                   ext_edge;
    logic                   trig_wr;
    logic                   ctrl_wr;
    logic                   ext_mode;
    logic                   xfer_all;
    logic [NUM_CH-1:0]      ch_wr;

    assign ctrl_wr  = bus.wr && bus.addr == CTRL_BYTE_OFS && bus.lane[1];
    // A byte or word write to the trigger byte; its data is ignored.
    assign trig_wr  = bus.wr && bus.addr == TRIG_BYTE_OFS;
    assign ext_mode = control_word_r.tmode == TM_EXT_RISE
                   || control_word_r.tmode == TM_EXT_FALL;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            control_word_r <= dacuc_ctrl_type'(CTRL_RST[5:0]);
        end else if (ctrl_wr) begin
            control_word_r.lamp_off      <= bus.wdata[LAMP_BIT];
            control_word_r.field_connect <= bus.wdata[FIELD_BIT];
            control_word_r.sync_drive    <= bus.wdata[SYNC_BIT];
            control_word_r.signed_fmt    <= bus.wdata[SIGNED_BIT];
            control_word_r.tmode         <=
                dacuc_tmode_type'(bus.wdata[TMODE_LO+:2]);
        end
    end

    // The first stage is read only by the second; edges use stages 2 and 3.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            trig_sync_r <= 3'h7;
        end else begin
            trig_sync_r <= {trig_sync_r[1:0], trig_pin_in};
        end
    end

    assign rise     = trig_sync_r[1] && !trig_sync_r[2];
    assign fall     = !trig_sync_r[1] && trig_sync_r[2];
    always_comb begin
        case (control_word_r.tmode)
            TM_EXT_RISE: ext_edge = rise;
            TM_EXT_FALL: ext_edge = fall;
            default:     ext_edge = 1'b0;
        endcase
    end
    // One global strobe keeps the latency fixed and the channels together.
    assign xfer_all = ext_edge
        || (trig_wr && control_word_r.tmode == TM_INTERNAL);

    // An edge in the same cycle as a clearing write wins over the clear.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            trigger_event_flags_r <= FLAGS_NONE;
        end else if (ext_edge) begin
            trigger_event_flags_r <= (trigger_event_flags_r == FLAGS_NONE)
                ? FLAGS_ONE : FLAGS_OVER;
        end else if (trig_wr && ext_mode) begin
            trigger_event_flags_r <= FLAGS_NONE;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign ch_wr[g] = bus.wr && bus.lane == 2'h3
                && bus.addr == 7'(DAC_FIRST_OFS + 2*g);
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    in_r[g] <= '0;
                end else if (ch_wr[g]) begin
                    in_r[g] <= bus.wdata[DAC_W-1:0];
                end
            end
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    out_r[g] <= '0;
                end else if (control_word_r.tmode == TM_AUTO && ch_wr[g]) begin
                    out_r[g] <= bus.wdata[DAC_W-1:0];
                end else if (xfer_all) begin
                    out_r[g] <= in_r[g];
                end
            end
            assign dac_out[g*DAC_W+:DAC_W] = out_r[g];
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            transfer_strobe <= 1'b0;
        end else begin
            transfer_strobe <= xfer_all;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (bus.rd && bus.addr == TRIG_BYTE_OFS) begin
            rdata <= {14'h0000, trigger_event_flags_r};
        end else if (bus.rd && bus.addr == CTRL_BYTE_OFS) begin
            rdata <= {control_word_r.lamp_off, control_word_r.field_connect,
                      control_word_r.sync_drive, 2'h0,
                      control_word_r.signed_fmt, control_word_r.tmode, 8'h00};
        end else if (bus.rd && bus.addr >= DAC_FIRST_OFS
                     && bus.addr <= DAC_LAST_OFS && !bus.addr[0]) begin
            rdata <= {4'h0, in_r[bus.addr[3:1] - 3'h4]};
        end else begin
            rdata <= '0;
        end
    end

    assign status_lamp_on = !control_word_r.lamp_off;
    assign field_connect  = control_word_r.field_connect;
    assign signed_fmt     = control_word_r.signed_fmt;
    assign trig_pin_out   = 1'b0;
    assign trig_pin_oe    = control_word_r.sync_drive;

    lamp_reset_a: assert property (@(posedge mclk)
        !rst_n |=> status_lamp_on && !trig_pin_oe)
        else $error("lamp not lit or pin driven after reset");
    pin_drive_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        ctrl_wr |=> trig_pin_oe == $past(bus.wdata[SYNC_BIT]))
        else $error("trigger pin drive does not follow control");
    lane_refuse_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        bus.wr && bus.addr == CTRL_BYTE_OFS && !bus.lane[1]
        |=> $stable(control_word_r))
        else $error("control changed on a refused byte write");
    int_trig_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        trig_wr && control_word_r.tmode == TM_INTERNAL |=> transfer_strobe)
        else $error("internal trigger write gave no transfer");
    ext_rise_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        control_word_r.tmode == TM_EXT_RISE && $rose(trig_sync_r[1])
        |=> transfer_strobe)
        else $error("rising edge gave no transfer");
    ext_wrong_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        control_word_r.tmode == TM_EXT_RISE && fall && !trig_wr
        |=> !transfer_strobe)
        else $error("falling edge transferred in rising mode");
    ext_write_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        trig_wr && ext_mode && !ext_edge |=> !transfer_strobe)
        else $error("trigger write transferred in external mode");
    auto_hold_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        control_word_r.tmode == TM_AUTO |=> !transfer_strobe)
        else $error("transfer strobe raised in automatic mode");
    flag_set_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        ext_edge && trigger_event_flags_r == FLAGS_NONE
        |=> trigger_event_flags_r == FLAGS_ONE)
        else $error("first edge did not set the flags to one");
    flag_over_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        ext_edge && trigger_event_flags_r != FLAGS_NONE
        |=> trigger_event_flags_r == FLAGS_OVER)
        else $error("second edge did not flag overrun");
    flag_clear_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        trig_wr && ext_mode && !ext_edge
        |=> trigger_event_flags_r == FLAGS_NONE)
        else $error("trigger write did not clear flags");
    all_copy_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        xfer_all && control_word_r.tmode != TM_AUTO
        |=> out_r[0] == $past(in_r[0]) && out_r[7] == $past(in_r[7]))
        else $error("transfer did not copy all channels");
    auto_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        control_word_r.tmode == TM_AUTO && ch_wr[3]
        |=> out_r[3] == $past(bus.wdata[DAC_W-1:0]))
        else $error("auto mode write not passed to output");
    // Boards on one trigger line stay aligned only if this delay never varies.
    edge_lat_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        control_word_r.tmode == TM_EXT_FALL && fall
        |=> transfer_strobe)
        else $error("falling edge latency not fixed");

    int_cov_c: cover property (@(posedge mclk)
        trig_wr && control_word_r.tmode == TM_INTERNAL);
    ext_cov_c: cover property (@(posedge mclk) ext_edge ##[1:30] ext_edge);
    fall_cov_c: cover property (@(posedge mclk)
        control_word_r.tmode == TM_EXT_FALL && fall);
    over_cov_c: cover property (@(posedge mclk)
        trigger_event_flags_r == FLAGS_OVER);
endmodule

// ===== bench/dacuc_trig_src.sv
// Trigger source model and the pulled-up trigger wire it shares.
`timescale 1ns/100ps
module dacuc_trig_src (
    // Source request and the device's open-drain pin.
    input  wire logic drive_low,
    input  wire logic dut_oe,
    input  wire logic dut_out,
    // Resolved wire level.
    output logic      pin
);
    // The pull-up wins only when nobody sinks the wire.
    assign pin = (drive_low || (dut_oe && !dut_out)) ? 1'b0 : 1'b1;
endmodule

// ===== bench/dacuc_top_test.sv
// Self-checking bench for the DAC update control.
`timescale 1ns/100ps
module dacuc_top_test;
    import dacuc_pkg::*;
    logic                    mclk = 1'b0;
    logic                    rst_n = 1'b0;
    dacuc_bus_type           bus = '0;
    logic                    src_low = 1'b0;
    logic                    pin, pin_out, pin_oe, lamp_on, fld, sgn, stb;
    logic                    rd_seen = 1'b0;
    logic [15:0]             rdata;
    logic [NUM_CH*DAC_W-1:0] dac_out;
    logic [15:0]             exp_q[$], msk_q[$];
    logic [DAC_W-1:0]        ch_val[NUM_CH] = '{default: '0};
    logic [DAC_W-1:0]        nv[NUM_CH];
    logic [31:0]             seed = 32'hd0ed;
    int                      n_mismatch = 0, checks = 0, n_stb = 0, cyc_n = 0;
    int                      la, lb;
    always #5 mclk = ~mclk;
    dacuc_top i_dut (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .trig_pin_in(pin), .trig_pin_out(pin_out), .trig_pin_oe(pin_oe),
        .status_lamp_on(lamp_on), .field_connect(fld), .signed_fmt(sgn),
        .transfer_strobe(stb), .dac_out(dac_out));
    dacuc_trig_src i_src (.drive_low(src_low), .dut_oe(pin_oe),
        .dut_out(pin_out), .pin(pin));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic stop_test;
        if (n_mismatch == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, e, m, input string what);
        checks++;
        if ((got & m) !== (e & m)) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic check_dac;
        for (int n = 0; n < NUM_CH; n++)
            check({4'h0, dac_out[n*DAC_W+:DAC_W]}, {4'h0, ch_val[n]},
                16'h0fff, "dac output");
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d,
                      input logic [1:0] ln);
        @(negedge mclk);
        bus.addr = a;
        bus.wdata = d;
        bus.lane = ln;
        bus.wr = 1'b1;
        @(negedge mclk);
        bus.wr = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e, m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(negedge mclk);
        bus.addr = a;
        bus.rd = 1'b1;
        @(negedge mclk);
        bus.rd = 1'b0;
    endtask
    task automatic ctrl(input logic [15:0] d);
        wr(CTRL_BYTE_OFS, d, 2'h3);
        cyc(1);
        check({12'h0, lamp_on, fld, pin_oe, sgn},
            {12'h0, ~d[15], d[14], d[13], d[10]}, 16'hf, "control pins");
        rd(CTRL_BYTE_OFS, d, 16'he700);
    endtask
    // Latency is the index of the cycle that shows the strobe, 0 if none.
    task automatic pin_set(input logic low, output int lat);
        lat = 0;
        src_low = low;
        for (int i = 1; i <= 12; i++) begin
            @(negedge mclk);
            if (stb === 1'b1) lat = i;
        end
    endtask
    always @(posedge mclk) begin
        rd_seen <= bus.rd;
        if (stb === 1'b1) n_stb++;
        cyc_n++;
        if (cyc_n == 6000) begin
            n_mismatch++;
            stop_test();
        end
    end
    always @(negedge mclk)
        if (rd_seen)
            check(rdata, exp_q.pop_front(), msk_q.pop_front(), "read");
    initial begin
        cyc(20);
        rst_n = 1'b1;
        check({12'h0, lamp_on, fld, pin_oe, sgn}, 16'h8, 16'hf, "reset");
        rd(CTRL_BYTE_OFS, 16'h0, 16'he700);
        for (int i = 0; i < 16; i++)
            ctrl({i[3:1], 2'b00, i[0], 10'h000});
        ctrl(16'h0000);
        for (int n = 0; n < NUM_CH; n++) begin
            seed = xs(seed);
            ch_val[n] = seed[11:0];
            wr(7'(DAC_FIRST_OFS + 2 * n), {4'h0, ch_val[n]}, 2'h3);
            cyc(1);
            check_dac();
        end
        wr(DAC_FIRST_OFS, 16'h0fff, 2'h1);
        wr(CTRL_BYTE_OFS, 16'h8000, 2'h1);
        cyc(2);
        check_dac();
        check({15'h0, lamp_on}, 16'h1, 16'h1, "lane refused");
        ctrl(16'h0300);
        for (int k = 0; k < 2; k++) begin
            for (int n = 0; n < NUM_CH; n++) begin
                seed = xs(seed);
                nv[n] = ~seed[11:0];
                wr(7'(DAC_FIRST_OFS + 2 * n), {4'h0, nv[n]}, 2'h3);
            end
            cyc(2);
            check_dac();
            rd(DAC_LAST_OFS, {4'h0, nv[NUM_CH-1]}, 16'hffff);
            seed = xs(seed);
            ch_val = nv;
            la = n_stb;
            wr(TRIG_BYTE_OFS, seed[15:0], k ? 2'h3 : 2'h1);
            cyc(3);
            check_dac();
            check(16'(n_stb - la), 16'h1, 16'hffff, "internal strobe");
        end
        for (int m = 1; m <= 2; m++) begin
            ctrl({6'h0, 2'(m), 8'h00});
            seed = xs(seed);
            wr(DAC_FIRST_OFS, {4'h0, seed[11:0]}, 2'h3);
            wr(TRIG_BYTE_OFS, 16'h0, 2'h1);
            cyc(2);
            check_dac();
            ch_val[0] = seed[11:0];
            pin_set(1'b1, la);
            pin_set(1'b0, lb);
            check(16'(m == 1 ? la : lb), 16'h0, 16'hffff, "wrong edge");
            check({15'h0, (m == 1 ? lb : la) inside {[2:5]}}, 16'h1, 16'h1,
                "edge latency");
            check_dac();
            rd(TRIG_BYTE_OFS, 16'h1, 16'h3);
            pin_set(1'b1, la);
            pin_set(1'b0, lb);
            rd(TRIG_BYTE_OFS, 16'h3, 16'h3);
            wr(TRIG_BYTE_OFS, 16'hffff, 2'h3);
            rd(TRIG_BYTE_OFS, 16'h0, 16'h3);
        end
        la = n_stb;
        ctrl(16'h2200);
        cyc(8);
        check(16'(n_stb - la), 16'h1, 16'hffff, "sync drive edge");
        ctrl(16'h0000);
        cyc(4);
        stop_test();
    end
endmodule
